// ---- host_port_enable_control.sv ----
// enable, drive and capture control of the parallel host port
`timescale 1ns/10ps
module host_port_enable_control (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pin clocks, sampled as ordinary inputs
  input wire logic receive_side_clock,
  input wire logic transmit_side_clock,
  input wire logic reference_clock,
  // host controls
  input wire logic chip_select_n,
  input wire logic receive_output_enable_n,
  input wire logic transmit_write_enable_n,
  input wire logic buffer_bypass_n,
  input wire logic external_buffer_mode,
  // receive path and flag conditions from the core
  input wire logic [host_port_pkg::WORD_W-1:0] receive_word_in,
  input wire logic receive_special_in,
  input wire logic receive_violation_in,
  input wire logic receive_nearly_full_in,
  input wire logic receive_half_in,
  input wire logic receive_empty_in,
  input wire logic [host_port_pkg::FLAG_W-1:0] transmit_flags_in,
  // transmit pins from the host
  input wire logic [host_port_pkg::WORD_W-1:0] transmit_word,
  input wire logic transmit_special_char_flag,
  input wire logic [host_port_pkg::CMD_W-1:0] transmit_command_bits,
  // receive data pins
  output logic [host_port_pkg::WORD_W-1:0] receive_word,
  output logic receive_special_char_flag,
  output logic code_violation_flag,
  output logic receive_data_oe_n,
  // receive flag pins
  output logic receive_buffer_nearly_full,
  output logic receive_half_flag,
  output logic receive_empty_flag,
  output logic receive_flags_oe_n,
  // transmit flag pins
  output logic [host_port_pkg::FLAG_W-1:0] transmit_flags,
  output logic transmit_flags_oe_n,
  // captured transmit words
  output logic buffer_write_valid,
  output logic [host_port_pkg::TX_W-1:0] buffer_write_data,
  output logic encoder_valid,
  output logic [host_port_pkg::TX_W-1:0] encoder_data
);
  import host_port_pkg::*;

  //------------------------------------------------------------
  // input sampling
  //------------------------------------------------------------
  sample_if #(.W(CLK_N)) clk_s ();
  sample_if #(.W(CTL_N)) ctl_s ();
  sample_if #(.W(RX_W + FLAG_W)) rx_s ();
  sample_if #(.W(TX_W + FLAG_W)) tx_s ();

  pin_sampler #(.W(CLK_N), .INIT(3'h0)) u_clk (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins({reference_clock, transmit_side_clock, receive_side_clock}),
    .smp(clk_s)
  );
  pin_sampler #(.W(CTL_N), .INIT(CTL_RESET)) u_ctl (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins({external_buffer_mode, buffer_bypass_n, transmit_write_enable_n,
      receive_output_enable_n, chip_select_n}),
    .smp(ctl_s)
  );
  pin_sampler #(.W(RX_W + FLAG_W), .INIT(15'h0000)) u_rx (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins({receive_empty_in, receive_half_in, receive_nearly_full_in,
      receive_violation_in, receive_special_in, receive_word_in}),
    .smp(rx_s)
  );
  pin_sampler #(.W(TX_W + FLAG_W), .INIT(16'h0000)) u_tx (
    .clk_sys(clk_sys),
    .reset(reset),
    .pins({transmit_flags_in, transmit_command_bits, transmit_special_char_flag,
      transmit_word}),
    .smp(tx_s)
  );

  logic rx_rise;
  logic tx_rise;
  logic ref_rise;
  logic cs_low;
  logic receive_output_enable_on;
  logic transmit_write_enable_on;
  logic buf_on;
  logic ext_high;
  logic [TX_W-1:0] tx_bits;

  // pin clocks must stay well below clk_sys/4 so each rise is seen once
  assign rx_rise = clk_s.level[CLK_RX] & ~clk_s.prev[CLK_RX];
  assign tx_rise = clk_s.level[CLK_TX] & ~clk_s.prev[CLK_TX];
  assign ref_rise = clk_s.level[CLK_REF] & ~clk_s.prev[CLK_REF];
  assign cs_low = ~ctl_s.level[CTL_CS];
  assign receive_output_enable_on = ~ctl_s.level[CTL_RECEIVE_OUTPUT_ENABLE];
  assign transmit_write_enable_on = ~ctl_s.level[CTL_TRANSMIT_WRITE_ENABLE];
  assign buf_on = ctl_s.level[CTL_BUF];
  assign ext_high = ctl_s.level[CTL_EXT];
  assign tx_bits = tx_s.level[TX_W-1:0];

  //------------------------------------------------------------
  // receive side
  //------------------------------------------------------------
  logic receive_output_enable_seen;
  logic next_receive_output_enable_seen;
  logic next_receive_data_oe_n;
  logic next_receive_flags_oe_n;
  logic [RX_W-1:0] rx_data;
  logic [RX_W-1:0] next_rx_data;
  logic [FLAG_W-1:0] rx_flags;
  logic [FLAG_W-1:0] next_rx_flags;
  logic full_active;

  always_comb
  begin
    next_receive_output_enable_seen = receive_output_enable_seen;
    next_receive_data_oe_n = receive_data_oe_n;
    next_receive_flags_oe_n = receive_flags_oe_n;
    next_rx_data = rx_data;
    next_rx_flags = rx_flags;
    // bypass hides the nearly-full condition from the pin
    full_active = buf_on & rx_s.level[RX_W];
    if (rx_rise)
    begin
      next_receive_output_enable_seen = receive_output_enable_on;
      next_receive_flags_oe_n = ~cs_low;
      next_rx_data = rx_s.level[RX_W-1:0];
      // asserted level follows the external buffer mode
      next_rx_flags[0] = full_active ? ext_high : ~ext_high;
      next_rx_flags[1] = buf_on & rx_s.level[RX_W+1];
      next_rx_flags[2] = rx_s.level[RX_W+2];
      if (!receive_output_enable_on)
        next_receive_data_oe_n = OE_OFF;
      else if (cs_low && !receive_output_enable_seen)
        next_receive_data_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      receive_output_enable_seen <= 1'b0;
      receive_data_oe_n <= OE_OFF;
      receive_flags_oe_n <= OE_OFF;
      rx_data <= '0;
      rx_flags <= '0;
    end
    else
    begin
      receive_output_enable_seen <= next_receive_output_enable_seen;
      receive_data_oe_n <= next_receive_data_oe_n;
      receive_flags_oe_n <= next_receive_flags_oe_n;
      rx_data <= next_rx_data;
      rx_flags <= next_rx_flags;
    end
  end

  assign receive_word = rx_data[WORD_W-1:0];
  assign receive_special_char_flag = rx_data[RX_SPECIAL];
  assign code_violation_flag = rx_data[RX_VIOL];
  assign receive_buffer_nearly_full = rx_flags[0];
  assign receive_half_flag = rx_flags[1];
  assign receive_empty_flag = rx_flags[2];

  //------------------------------------------------------------
  // transmit side
  //------------------------------------------------------------
  stream_state_t stream;
  stream_state_t next_stream;
  logic transmit_write_enable_ref_seen;
  logic next_transmit_write_enable_ref_seen;
  logic next_transmit_flags_oe_n;
  logic [FLAG_W-1:0] next_transmit_flags;
  logic next_buffer_write_valid;
  logic [TX_W-1:0] next_buffer_write_data;
  logic next_encoder_valid;
  logic [TX_W-1:0] next_encoder_data;

  always_comb
  begin
    next_stream = stream;
    next_transmit_write_enable_ref_seen = transmit_write_enable_ref_seen;
    next_transmit_flags_oe_n = transmit_flags_oe_n;
    next_transmit_flags = transmit_flags;
    next_buffer_write_valid = 1'b0;
    next_buffer_write_data = buffer_write_data;
    next_encoder_valid = 1'b0;
    next_encoder_data = encoder_data;
    if (tx_rise)
    begin
      next_transmit_flags = tx_s.level[TX_W+FLAG_W-1:TX_W];
      if (buf_on && cs_low)
      begin
        next_transmit_flags_oe_n = 1'b0;
        if (transmit_write_enable_on)
        begin
          next_buffer_write_valid = 1'b1;
          next_buffer_write_data = tx_bits;
        end
      end
    end
    if (ref_rise)
    begin
      next_transmit_write_enable_ref_seen = transmit_write_enable_on;
      if (!cs_low)
        next_transmit_flags_oe_n = OE_OFF;
      // leaving bypass or losing chip select ends the stream on the next reference clock rise
      if (buf_on || !cs_low || !transmit_write_enable_on)
        next_stream = STREAM_IDLE;
      else
      begin
        case (stream)
          STREAM_IDLE:
          begin
            if (!transmit_write_enable_ref_seen)
            begin
              next_stream = STREAM_RUN;
              next_encoder_valid = 1'b1;
              next_encoder_data = tx_bits;
            end
          end
          STREAM_RUN:
          begin
            next_encoder_valid = 1'b1;
            next_encoder_data = tx_bits;
          end
          default:
            next_stream = STREAM_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stream <= STREAM_IDLE;
      transmit_write_enable_ref_seen <= 1'b0;
      transmit_flags_oe_n <= OE_OFF;
      transmit_flags <= '0;
      buffer_write_valid <= 1'b0;
      buffer_write_data <= '0;
      encoder_valid <= 1'b0;
      encoder_data <= '0;
    end
    else
    begin
      stream <= next_stream;
      transmit_write_enable_ref_seen <= next_transmit_write_enable_ref_seen;
      transmit_flags_oe_n <= next_transmit_flags_oe_n;
      transmit_flags <= next_transmit_flags;
      buffer_write_valid <= next_buffer_write_valid;
      buffer_write_data <= next_buffer_write_data;
      encoder_valid <= next_encoder_valid;
      encoder_data <= next_encoder_data;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_rx_flags_on: assert property (rx_rise && cs_low |=> !receive_flags_oe_n)
    else $error("receive flags not driven after low chip select");
  a_rx_flags_off: assert property (rx_rise && !cs_low |=> receive_flags_oe_n)
    else $error("receive flags not floated after high chip select");
  a_rx_data_on: assert property (rx_rise && cs_low && receive_output_enable_on && !receive_output_enable_seen
    |=> !receive_data_oe_n && receive_word == $past(rx_s.level[WORD_W-1:0]))
    else $error("receive data not enabled on enable edge");
  a_rx_data_hold: assert property (!receive_data_oe_n && !(rx_rise && !receive_output_enable_on)
    |=> !receive_data_oe_n)
    else $error("receive data released early");
  a_tx_flags_on: assert property (tx_rise && buf_on && cs_low |=> !transmit_flags_oe_n)
    else $error("transmit flags not driven");
  a_tx_flags_off: assert property (ref_rise && !cs_low |=> transmit_flags_oe_n)
    else $error("transmit flags not floated");
  a_buffer_write: assert property (tx_rise && buf_on && cs_low && transmit_write_enable_on
    |=> buffer_write_valid && buffer_write_data == $past(tx_bits))
    else $error("transmit word not written to buffer");
  a_bypass_start: assert property (ref_rise && !buf_on && cs_low && transmit_write_enable_on && !transmit_write_enable_ref_seen
    |=> encoder_valid && stream == STREAM_RUN ##1 !encoder_valid)
    else $error("bypass capture did not start");
  a_bypass_stream: assert property (stream == STREAM_RUN && ref_rise && !buf_on && cs_low
    && transmit_write_enable_on |=> encoder_valid && encoder_data == $past(tx_bits))
    else $error("bypass word missed");
  a_bypass_stop: assert property (ref_rise && !transmit_write_enable_on
    |=> !encoder_valid && stream == STREAM_IDLE)
    else $error("bypass capture did not stop");
  a_full_bypass: assert property (rx_rise && !buf_on
    |=> receive_buffer_nearly_full == !$past(ext_high))
    else $error("nearly full not deasserted in bypass");
  a_full_polarity: assert property (rx_rise && buf_on && rx_s.level[RX_W]
    |=> receive_buffer_nearly_full == $past(ext_high))
    else $error("nearly full polarity wrong");

  c_rx_data_on: cover property (receive_data_oe_n ##1 !receive_data_oe_n);
  c_buffer_write: cover property (buffer_write_valid);
  c_bypass_run: cover property (encoder_valid ##[1:20] encoder_valid);
  c_tx_float: cover property (!transmit_flags_oe_n ##1 transmit_flags_oe_n);
endmodule // host_port_enable_control

// ---- host_port_pkg.sv ----
// constants and types for the host port enable control
//------------------------------------------------------------
// What this block does
// - Chip select is active low, and a low sample on a receive clock rise drives the receive flags.
// - A high chip select sample on a receive clock rise floats the receive flag outputs.
// - Receive word, special flag and violation outputs turn on when chip select is low and the receive output enable goes from off to on between receive clock rises.
// - The receive data outputs stay driven until the receive output enable is sampled off on a receive clock rise.
// - With the transmit buffer in use, a low chip select sample on a transmit clock rise drives the transmit flags.
// - A high chip select sample on a reference clock rise floats the transmit flag outputs.
// - With the buffer in use and chip select low, the host's word, special flag and command bits are written to the buffer on each transmit clock rise that sees the write enable on.
// - With the buffer bypassed and chip select low, the transmit inputs are captured on the reference clock once the write enable turns on and go straight to the encoder path.
// - In bypass the inputs are captured on each later reference clock rise with chip select low and write enable on, so the host gives a fresh word each time.
// - The bypass control uses the receive buffer when high and, when low, holds the nearly-full flag deasserted.
// - The external buffer mode input makes the nearly-full flag active low when low and active high when high.
//------------------------------------------------------------
package host_port_pkg;
  localparam int WORD_W = 10;
  localparam int CMD_W = 2;
  localparam int TX_W = WORD_W + 1 + CMD_W;
  localparam int RX_W = WORD_W + 2;
  localparam int FLAG_W = 3;
  // bit positions in the sampled pin-clock vector
  localparam int CLK_N = 3;
  localparam int CLK_RX = 0;
  localparam int CLK_TX = 1;
  localparam int CLK_REF = 2;
  // bit positions in the sampled control vector
  localparam int CTL_N = 5;
  localparam int CTL_CS = 0;
  localparam int CTL_RECEIVE_OUTPUT_ENABLE = 1;
  localparam int CTL_TRANSMIT_WRITE_ENABLE = 2;
  localparam int CTL_BUF = 3;
  localparam int CTL_EXT = 4;
  // bit positions in the receive vector
  localparam int RX_SPECIAL = WORD_W;
  localparam int RX_VIOL = WORD_W + 1;
  // reset values
  localparam logic OE_OFF = 1'b1;
  localparam logic [CTL_N-1:0] CTL_RESET = 5'h0f;
  typedef enum logic {
    STREAM_IDLE = 1'b0,
    STREAM_RUN = 1'b1
  } stream_state_t;
endpackage

// ---- sample_if.sv ----
// sampled pin group: settled level and the sample before it
`timescale 1ns/10ps
interface sample_if #(parameter int W = 1);
  logic [W-1:0] level;
  logic [W-1:0] prev;
  modport src (output level, output prev);
  modport dst (input level, input prev);
endinterface

// ---- pin_sampler.sv ----
// two-flop synchroniser with one extra stage for edge detection
`timescale 1ns/10ps
module pin_sampler #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // asynchronous pins in, settled samples out
  input wire logic [W-1:0] pins,
  sample_if.src smp
);
  logic [W-1:0] meta;
  logic [W-1:0] settled;
  logic [W-1:0] older;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_settled;
  logic [W-1:0] next_older;

  // meta is read by the second stage only
  always_comb
  begin
    next_meta = pins;
    next_settled = meta;
    next_older = settled;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta <= INIT;
      settled <= INIT;
      older <= INIT;
    end
    else
    begin
      meta <= next_meta;
      settled <= next_settled;
      older <= next_older;
    end
  end

  assign smp.level = settled;
  assign smp.prev = older;
endmodule // pin_sampler

// ---- host_model.sv ----
// host side model: pin clocks, controls, words and the expected device state
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk_sys,
  // host pins and core-side conditions
  output logic receive_side_clock,
  output logic transmit_side_clock,
  output logic reference_clock,
  output logic chip_select_n,
  output logic receive_output_enable_n,
  output logic transmit_write_enable_n,
  output logic buffer_bypass_n,
  output logic external_buffer_mode,
  output logic [host_port_pkg::WORD_W-1:0] receive_word_in,
  output logic receive_special_in,
  output logic receive_violation_in,
  output logic receive_nearly_full_in,
  output logic receive_half_in,
  output logic receive_empty_in,
  output logic [host_port_pkg::FLAG_W-1:0] transmit_flags_in,
  output logic [host_port_pkg::WORD_W-1:0] transmit_word,
  output logic transmit_special_char_flag,
  output logic [host_port_pkg::CMD_W-1:0] transmit_command_bits
);
  import host_port_pkg::*;
  integer seed = 82;
  logic exp_rx_flags_oe_n = 1'b1;
  logic exp_rx_data_oe_n = 1'b1;
  logic exp_tx_flags_oe_n = 1'b1;
  logic [RX_W-1:0] exp_rx = '0;
  logic [2:0] exp_rx_flags = '0;
  logic [FLAG_W-1:0] exp_tx_flags = '0;
  logic rx_prev = 1'b1;
  logic ref_prev = 1'b1;
  logic run = 1'b0;
  logic [TX_W-1:0] wq[$];
  logic [TX_W-1:0] eq[$];
  initial
  begin
    {reference_clock, transmit_side_clock, receive_side_clock} = 3'h0;
    {external_buffer_mode, buffer_bypass_n, transmit_write_enable_n} = 3'h3;
    {receive_output_enable_n, chip_select_n} = 2'h3;
    {receive_violation_in, receive_special_in, receive_word_in} = '0;
    {receive_nearly_full_in, receive_half_in, receive_empty_in, transmit_flags_in} = '0;
    {transmit_command_bits, transmit_special_char_flag, transmit_word} = '0;
  end
  //------------------------------------------------------------
  // one pin-clock period: 5 cycles low, 5 high, pins held around the rise
  //------------------------------------------------------------
  task automatic step(input logic [CLK_N-1:0] clks, input logic [CTL_N-1:0] ctl);
    logic [TX_W-1:0] txw;
    logic [RX_W-1:0] rxw;
    logic [5:0] raw;
    logic on;
    txw = TX_W'($random(seed));
    rxw = RX_W'($random(seed));
    raw = 6'($random(seed));
    on = ctl[CTL_BUF];
    @(posedge clk_sys);
    chip_select_n <= ctl[CTL_CS];
    receive_output_enable_n <= ctl[CTL_RECEIVE_OUTPUT_ENABLE];
    transmit_write_enable_n <= ctl[CTL_TRANSMIT_WRITE_ENABLE];
    buffer_bypass_n <= ctl[CTL_BUF];
    external_buffer_mode <= ctl[CTL_EXT];
    {transmit_command_bits, transmit_special_char_flag, transmit_word} <= txw;
    {receive_violation_in, receive_special_in, receive_word_in} <= rxw;
    {receive_nearly_full_in, receive_half_in, receive_empty_in, transmit_flags_in} <= raw;
    repeat (4) @(posedge clk_sys);
    {reference_clock, transmit_side_clock, receive_side_clock} <= clks;
    if (clks[CLK_RX])
    begin
      exp_rx_flags_oe_n = ctl[CTL_CS];
      if (!ctl[CTL_CS] && !ctl[CTL_RECEIVE_OUTPUT_ENABLE] && rx_prev)
        exp_rx_data_oe_n = 1'b0;
      else if (ctl[CTL_RECEIVE_OUTPUT_ENABLE])
        exp_rx_data_oe_n = 1'b1;
      rx_prev = ctl[CTL_RECEIVE_OUTPUT_ENABLE];
      exp_rx = rxw;
      // bypass holds nearly-full at its deasserted level, whatever the polarity
      exp_rx_flags[2] = on ? (raw[5] ^ ~ctl[CTL_EXT]) : ~ctl[CTL_EXT];
      exp_rx_flags[1:0] = {raw[4] & on, raw[3]};
    end
    if (clks[CLK_TX])
    begin
      exp_tx_flags = raw[2:0];
      if (on && !ctl[CTL_CS])
        exp_tx_flags_oe_n = 1'b0;
      if (on && !ctl[CTL_CS] && !ctl[CTL_TRANSMIT_WRITE_ENABLE])
        wq.push_back(txw);
    end
    if (clks[CLK_REF])
    begin
      if (ctl[CTL_CS])
        exp_tx_flags_oe_n = 1'b1;
      run = !on && !ctl[CTL_CS] && !ctl[CTL_TRANSMIT_WRITE_ENABLE] && (run || ref_prev);
      if (run)
        eq.push_back(txw);
      ref_prev = ctl[CTL_TRANSMIT_WRITE_ENABLE];
    end
    repeat (5) @(posedge clk_sys);
    {reference_clock, transmit_side_clock, receive_side_clock} <= 3'h0;
  endtask
endmodule // host_model

// ---- testbench.sv ----
// self-checking bench for the host port enable control
`timescale 1ns/10ps
module testbench;
  import host_port_pkg::*;
  logic clk_sys;
  logic reset;
  logic receive_side_clock, transmit_side_clock, reference_clock, chip_select_n;
  logic receive_output_enable_n, transmit_write_enable_n, buffer_bypass_n;
  logic external_buffer_mode, receive_special_in, receive_violation_in;
  logic receive_nearly_full_in, receive_half_in, receive_empty_in, transmit_special_char_flag;
  logic [WORD_W-1:0] receive_word_in, transmit_word, receive_word;
  logic [FLAG_W-1:0] transmit_flags_in, transmit_flags;
  logic [CMD_W-1:0] transmit_command_bits;
  logic receive_special_char_flag, code_violation_flag, receive_data_oe_n;
  logic receive_buffer_nearly_full, receive_half_flag, receive_empty_flag;
  logic receive_flags_oe_n, transmit_flags_oe_n, buffer_write_valid, encoder_valid;
  logic [TX_W-1:0] buffer_write_data, encoder_data;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  // directed plan: {clocks, ext, buf, transmit_write_enable_n, receive_output_enable_n, cs_n}
  logic [7:0] plan [16] = '{8'h2e, 8'h2c, 8'h2d, 8'h2f, 8'h2d, 8'h48, 8'h48, 8'h48,
    8'h8f, 8'h86, 8'hc2, 8'hc2, 8'hc2, 8'h86, 8'h36, 8'h3e};
  host_model host_u (.*);
  host_port_enable_control dut_u (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  //------------------------------------------------------------
  // comparison and closing
  //------------------------------------------------------------
  task automatic check(input logic [TX_W-1:0] got, input logic [TX_W-1:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_state();
    @(negedge clk_sys);
    check(TX_W'(receive_flags_oe_n), TX_W'(host_u.exp_rx_flags_oe_n),
      "rx flag enable");
    check(TX_W'(receive_data_oe_n), TX_W'(host_u.exp_rx_data_oe_n),
      "rx data enable");
    check(TX_W'({code_violation_flag, receive_special_char_flag, receive_word}),
      TX_W'(host_u.exp_rx), "rx word");
    check(TX_W'({receive_buffer_nearly_full, receive_half_flag, receive_empty_flag}),
      TX_W'(host_u.exp_rx_flags), "rx flags");
    check(TX_W'(transmit_flags_oe_n), TX_W'(host_u.exp_tx_flags_oe_n),
      "tx flag enable");
    check(TX_W'(transmit_flags), TX_W'(host_u.exp_tx_flags), "tx flags");
  endtask
  //------------------------------------------------------------
  // capture monitor: every pulse must match the oldest noted word
  //------------------------------------------------------------
  // looked at mid-cycle, where each one-cycle pulse has settled
  always @(negedge clk_sys)
  begin
    if (buffer_write_valid === 1'b1)
    begin
      if (host_u.wq.size() == 0)
        check(TX_W'(1'b1), TX_W'(1'b0), "unexpected buffer write");
      else
        check(buffer_write_data, host_u.wq.pop_front(), "buffer write");
    end
    if (encoder_valid === 1'b1)
    begin
      if (host_u.eq.size() == 0)
        check(TX_W'(1'b1), TX_W'(1'b0), "unexpected encoder word");
      else
        check(encoder_data, host_u.eq.pop_front(), "encoder word");
    end
  end
  // the run needs under 1000 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      summarize();
    end
  end
  initial
  begin
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(TX_W'({receive_data_oe_n, receive_flags_oe_n, transmit_flags_oe_n}),
      TX_W'(3'h7), "reset enables");
    foreach (plan[i])
    begin
      host_u.step(plan[i][7:5], plan[i][4:0]);
      check_state();
    end
    repeat (60)
    begin
      host_u.step(CLK_N'($random(host_u.seed)), CTL_N'($random(host_u.seed)));
      check_state();
    end
    repeat (10) @(posedge clk_sys);
    check(TX_W'(host_u.wq.size() + host_u.eq.size()), TX_W'(1'b0),
      "captures left unseen");
    summarize();
  end
endmodule // testbench
